// >>> design/mailbox_pkg.sv
// Functional notes
// - Eight message registers, external read/write.
// - External vector write raises high-priority interrupt.
// - Service pushes status stack, jumps to vector.
// - Low 24 bits address, top 8 data.
// - Reset loads default vector table entry.
// - Six cycles to routine, five NOPs.
// - Return from interrupt pops status stack.
// - Write while pending replaces pending address.
// - External write while servicing is discarded.
// - Own core vector writes never trigger; stored only while servicing.
// - Pending bit sets on write, clears on return.
// - Direct-write pending within twelve cycles.
// - Control write may overtake direct write.
// - Master polls vector token, target writes token.
// - Interrupt messaging: fill messages, target writes zero.
// - Handshake: data then flag one, receiver zeroes.
// - Write-back: nonzero means data, zero cleared.
// - Host-mastership bit follows host bus grant.
// - Arbitration-synced bit set after synchronisation.
// - Master ID field reads 1 when own ID zero.
// - Pack stage: 00 done, 01 first, 10 second.
package mailbox_pkg;

  // ==========================================================
  // Register map (word indices)
  localparam logic [3:0]  MSG_BASE_IDX     = 4'h0;  // message_regs 0..7
  localparam logic [3:0]  VECTOR_IDX       = 4'h8;  // vector_interrupt_address
  localparam logic [3:0]  STATUS_IDX       = 4'h9;  // system_status
  localparam int          MSG_COUNT        = 8;
  localparam logic [31:0] VECTOR_RESET     = 32'h0000_0000;
  localparam logic [31:0] MSG_RESET        = 32'h0000_0000;

  // ==========================================================
  // Status field positions
  localparam int ST_HOST_POS   = 0;
  localparam int ST_SYNC_POS   = 1;
  localparam int ST_MASTER_POS = 8;
  localparam int ST_OWNID_POS  = 11;
  localparam int ST_DWP_POS    = 15;
  localparam int ST_VIP_POS    = 16;
  localparam int ST_PACK_POS   = 17;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int VEC_LATENCY_CYC   = 6;   // trigger to first routine fetch
  localparam int VEC_NOP_CYC       = 5;
  localparam int DWP_MAX_NS        = 60;  // 12 cycles at 5 ns
  localparam int DWP_MAX_CYC       = (DWP_MAX_NS * 1000) / CLK_PERIOD_PS;

  // Register access from the shared bus or the own core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        from_core;
    logic [3:0]  index;
    logic [31:0] wdata;
  } reg_req_type;

  // Observed arbitration / packing state
  typedef struct packed {
    logic       host_owns_bus;
    logic       arbitration_synced;
    logic [2:0] current_master_id;
    logic [2:0] own_id_code;
    logic [1:0] host_pack_stage;
  } sys_obs_type;

  typedef enum logic [2:0] {
    VI_IDLE    = 3'b001,
    VI_LATENCY = 3'b010,
    VI_SERVICE = 3'b100
  } vi_state_type;

endpackage : mailbox_pkg

// >>> design/message_bank.sv
// ============================================================
// Message register bank
module message_bank
  import mailbox_pkg::*;
#(
  parameter int COUNT = MSG_COUNT
)(
  input  wire logic        core_clk_i,  // Clock
  input  wire logic        rstn_i,      // Async reset, low
  input  wire logic        wr_i,        // Write strobe
  input  wire logic [2:0]  sel_i,       // Register select
  input  wire logic [31:0] wdata_i,     // Write data
  output logic      [31:0] rdata_o      // Read data, selected
);

  logic [31:0] msg_reg  [COUNT];
  logic [31:0] msg_next [COUNT];

  // Plain storage; the messaging conventions live in software
  always_comb
  begin
    for (int i = 0; i < COUNT; i++)
    begin
      msg_next[i] = msg_reg[i];
    end
    if (wr_i)
    begin
      msg_next[sel_i] = wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < COUNT; i++)
      begin
        msg_reg[i] <= MSG_RESET;
      end
    end
    else
    begin
      for (int i = 0; i < COUNT; i++)
      begin
        msg_reg[i] <= msg_next[i];
      end
    end
  end

  assign rdata_o = msg_reg[sel_i];

endmodule // message_bank

// >>> design/status_view.sv
// ============================================================
// System status assembly, read-only
module status_view
  import mailbox_pkg::*;
(
  input  wire logic        core_clk_i,  // Clock
  input  wire logic        rstn_i,      // Async reset, low
  input  sys_obs_type      obs_i,       // Observed state
  input  wire logic        dwp_i,       // Direct write pending
  input  wire logic        vip_i,       // Vector irq pending
  output logic      [31:0] status_o     // Status word, registered
);

  logic [31:0] status_reg;
  logic [31:0] status_next;

  // Build word from inputs only; no write path exists
  always_comb
  begin
    status_next = 32'h0000_0000;
    status_next[ST_HOST_POS] = obs_i.host_owns_bus;
    status_next[ST_SYNC_POS] = obs_i.arbitration_synced;
    status_next[ST_MASTER_POS +: 3] = (obs_i.own_id_code == 3'h0) ? 3'h1
                                     : obs_i.current_master_id;
    status_next[ST_OWNID_POS +: 3] = obs_i.own_id_code;
    status_next[ST_DWP_POS] = dwp_i;
    status_next[ST_VIP_POS] = vip_i;
    status_next[ST_PACK_POS +: 2] = (obs_i.host_pack_stage == 2'h3) ? 2'h0
                                   : obs_i.host_pack_stage;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      status_reg <= 32'h0000_0000;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  assign status_o = status_reg;

endmodule // status_view

// >>> design/interprocessor_mailbox_vector_irq.sv
// ============================================================
// Mailbox and vector interrupt slave
module interprocessor_mailbox_vector_irq
  import mailbox_pkg::*;
#(
  parameter logic [31:0] VECTOR_DEFAULT = VECTOR_RESET  // Table entry
)(
  input  wire logic        core_clk_i,      // Clock 200 MHz
  input  wire logic        rstn_i,          // Async reset, low
  input  reg_req_type      req_i,           // Register access
  output logic      [31:0] rdata_o,         // Read data, registered
  output logic             rvalid_o,        // Read data valid pulse
  input  sys_obs_type      obs_i,           // Arbitration/packing view
  input  wire logic        dw_start_i,      // Direct write accepted
  input  wire logic        dw_done_i,       // Direct write finished
  input  wire logic        rti_i,           // Return from interrupt
  output logic             irq_push_o,      // Push status stack pulse
  output logic             irq_pop_o,       // Pop status stack pulse
  output logic             irq_nop_o,       // Core issues NOP
  output logic             irq_branch_o,    // Branch to vector pulse
  output logic      [23:0] irq_target_o     // Branch address
);

  // ==========================================================
  // Decode
  logic ext_wr;
  logic vec_wr;
  logic msg_wr;
  assign ext_wr = req_i.valid && req_i.write && !req_i.from_core;
  assign msg_wr = req_i.valid && req_i.write && (req_i.index < VECTOR_IDX);
  // Core writes to the vector register never trigger; only service stores them
  assign vec_wr = ext_wr && (req_i.index == VECTOR_IDX);

  logic [31:0] msg_rdata;
  logic [31:0] status_word;

  message_bank #(.COUNT(MSG_COUNT)) u_msg (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .wr_i       (msg_wr),
    .sel_i      (req_i.index[2:0]),
    .wdata_i    (req_i.wdata),
    .rdata_o    (msg_rdata)
  );

  // ==========================================================
  // Vector state machine
  vi_state_type vi_reg;
  vi_state_type vi_next;
  logic [31:0]  vec_reg;
  logic [31:0]  vec_next;
  logic [2:0]   lat_reg;
  logic [2:0]   lat_next;
  logic         vip_reg;
  logic         vip_next;

  always_comb
  begin
    vi_next  = vi_reg;
    vec_next = vec_reg;
    lat_next = lat_reg;
    vip_next = vip_reg;
    unique case (vi_reg)
      VI_IDLE:
      begin
        if (vec_wr)
        begin
          vec_next = req_i.wdata;
          vip_next = 1'b1;
          vi_next  = VI_LATENCY;
          lat_next = 3'h0;
        end
      end
      VI_LATENCY:
      begin
        // Still pending: newest address wins
        if (vec_wr)
        begin
          vec_next = req_i.wdata;
        end
        lat_next = lat_reg + 3'h1;
        if (lat_reg == 3'(VEC_LATENCY_CYC - 1))
        begin
          vi_next = VI_SERVICE;
        end
      end
      VI_SERVICE:
      begin
        // External writes ignored here; core token write is allowed
        if (req_i.valid && req_i.write && req_i.from_core && req_i.index == VECTOR_IDX)
        begin
          vec_next = req_i.wdata;
        end
        if (rti_i)
        begin
          vip_next = 1'b0;
          vi_next  = VI_IDLE;
        end
      end
      default:
      begin
        vi_next = VI_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      vi_reg  <= VI_IDLE;
      vec_reg <= VECTOR_DEFAULT;
      lat_reg <= 3'h0;
      vip_reg <= 1'b0;
    end
    else
    begin
      vi_reg  <= vi_next;
      vec_reg <= vec_next;
      lat_reg <= lat_next;
      vip_reg <= vip_next;
    end
  end

  // Core sequencing signals
  assign irq_push_o   = (vi_reg == VI_LATENCY) && (lat_reg == 3'h0);
  assign irq_nop_o    = (vi_reg == VI_LATENCY) && (lat_reg != 3'h0);
  assign irq_branch_o = (vi_reg == VI_LATENCY) && (lat_reg == 3'(VEC_LATENCY_CYC - 1));
  assign irq_target_o = vec_reg[23:0];
  assign irq_pop_o    = (vi_reg == VI_SERVICE) && rti_i;

  // ==========================================================
  // Direct write tracking; control writes do not wait on it
  logic dwp_reg;
  logic dwp_next;
  always_comb
  begin
    dwp_next = dwp_reg;
    if (dw_done_i)
    begin
      dwp_next = 1'b0;
    end
    if (dw_start_i)
    begin
      dwp_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dwp_reg <= 1'b0;
    end
    else
    begin
      dwp_reg <= dwp_next;
    end
  end

  status_view u_status (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .obs_i      (obs_i),
    .dwp_i      (dwp_reg),
    .vip_i      (vip_reg),
    .status_o   (status_word)
  );

  // ==========================================================
  // Read port, one cycle after request
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic        rv_reg;
  logic        rv_next;
  always_comb
  begin
    rv_next = req_i.valid && !req_i.write;
    rd_next = rd_reg;
    if (rv_next)
    begin
      if (req_i.index < VECTOR_IDX)
      begin
        rd_next = msg_rdata;
      end
      else if (req_i.index == VECTOR_IDX)
      begin
        rd_next = vec_reg;
      end
      else if (req_i.index == STATUS_IDX)
      begin
        rd_next = status_word;
      end
      else
      begin
        rd_next = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rd_reg <= 32'h0000_0000;
      rv_reg <= 1'b0;
    end
    else
    begin
      rd_reg <= rd_next;
      rv_reg <= rv_next;
    end
  end

  assign rdata_o  = rd_reg;
  assign rvalid_o = rv_reg;

  // ==========================================================
  // Direct write age, for the completion bound check
  logic [3:0] dwp_age_reg;
  logic [3:0] dwp_age_next;

  // Restarts on every accepted write, so chained writes are judged one by one
  always_comb
  begin
    dwp_age_next = 4'h0;
    if (dwp_reg && !dw_start_i)
    begin
      dwp_age_next = (dwp_age_reg == 4'hf) ? dwp_age_reg : dwp_age_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      dwp_age_reg <= 4'h0;
    end
    else
    begin
      dwp_age_reg <= dwp_age_next;
    end
  end

  // ==========================================================
  // Checks
  // Trigger and sequencing
  vec_core_ign_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_i.valid && req_i.write && req_i.from_core && vi_reg == VI_IDLE) |=> vi_reg == VI_IDLE)
    else $error("core write triggered vector");
  vec_trig_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (vi_reg == VI_IDLE && vec_wr) |=> vip_reg && irq_push_o)
    else $error("vector write did not trigger");
  vec_lat_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(irq_push_o) |-> ##5 irq_branch_o)
    else $error("vector latency wrong");
  vec_nop_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(irq_push_o) |=> irq_nop_o [*5])
    else $error("nop count wrong");
  push_once_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    irq_push_o |=> !irq_push_o)
    else $error("status push repeated");
  branch_serv_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    irq_branch_o |=> vi_reg == VI_SERVICE)
    else $error("branch did not enter service");

  // Vector register updates
  vec_repl_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (vi_reg == VI_LATENCY && vec_wr) |=> vec_reg == $past(req_i.wdata))
    else $error("pending vector not replaced");
  vec_drop_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (vi_reg == VI_SERVICE && vec_wr) |=> $stable(vec_reg))
    else $error("write in service not dropped");
  vec_token_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (vi_reg == VI_SERVICE && req_i.valid && req_i.write && req_i.from_core
     && req_i.index == VECTOR_IDX) |=> vec_reg == $past(req_i.wdata))
    else $error("token write lost");

  // Pending flags
  vip_clr_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    irq_pop_o |=> !vip_reg && !irq_push_o)
    else $error("pending not cleared on return");
  vip_busy_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (vi_reg != VI_IDLE) |-> vip_reg)
    else $error("pending low while busy");
  pop_vip_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    irq_pop_o |-> vip_reg && vi_reg == VI_SERVICE)
    else $error("pop outside service");
  dwp_set_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    dw_start_i |=> dwp_reg)
    else $error("direct write pending missed");
  dwp_clr_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (dw_done_i && !dw_start_i) |=> !dwp_reg)
    else $error("direct write pending stuck");
  dwp_age_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    dwp_age_reg <= 4'(DWP_MAX_CYC))
    else $error("direct write pending too long");

  // Register port
  rd_valid_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_i.valid && !req_i.write) |=> rvalid_o)
    else $error("read not answered");
  stat_ro_a : assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (req_i.valid && req_i.write && req_i.index == STATUS_IDX) |=> $stable(vec_reg))
    else $error("status write had effect");

endmodule // interprocessor_mailbox_vector_irq

// >>> verif/direct_write_master.sv
// ==========================================================
// Far-side master issuing direct writes to internal memory
module direct_write_master
(
  input  wire logic       core_clk_i,  // Clock
  input  wire logic       rstn_i,      // Async reset, low
  input  wire logic       go_i,        // Start one direct write
  input  wire logic [3:0] delay_i,     // Cycles until completion
  output logic            dw_start_o,  // Write accepted pulse
  output logic            dw_done_o    // Write finished pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_reg;

  // Completion delay_i cycles after start, for delay_i of 1 to 15
  always @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cnt_reg    <= 4'h0;
      dw_start_o <= 1'b0;
      dw_done_o  <= 1'b0;
    end
    else
    begin
      dw_start_o <= go_i;
      dw_done_o  <= (cnt_reg == 4'h1);
      if (go_i)
        cnt_reg <= delay_i;
      else if (cnt_reg != 4'h0)
        cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule // direct_write_master

// >>> verif/interprocessor_mailbox_vector_irq_test.sv
// ==========================================================
// Self-checking bench for the mailbox and vector interrupt
module interprocessor_mailbox_vector_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  import mailbox_pkg::*;
  logic        core_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  reg_req_type req = '0;
  sys_obs_type obs = '0;
  logic        return_from_interrupt = 1'b0;
  logic        go = 1'b0;
  logic [3:0]  dly = 4'h1;
  logic        dw_start, dw_done, rvalid, push, pop, nop, branch;
  logic [31:0] rdata, d, a, b;
  logic [23:0] target;
  logic [31:0] msg [8];
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          n;

  always #2.5 core_clk_i = ~core_clk_i;

  interprocessor_mailbox_vector_irq i_interprocessor_mailbox_vector_irq (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
    .obs_i(obs), .dw_start_i(dw_start), .dw_done_i(dw_done), .rti_i(return_from_interrupt), .irq_push_o(push),
    .irq_pop_o(pop), .irq_nop_o(nop), .irq_branch_o(branch), .irq_target_o(target));

  direct_write_master i_direct_write_master (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .go_i(go), .delay_i(dly),
    .dw_start_o(dw_start), .dw_done_o(dw_done));

  // ==========================================================
  // Checking and bus tasks
  task automatic report_and_stop();
    $display("Comparisons %0d, errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle request, answer sampled the cycle after it is taken
  task automatic rd(input logic [3:0] idx, output logic [31:0] data);
    @(negedge core_clk_i);
    req = '{valid: 1'b1, write: 1'b0, from_core: 1'b0, index: idx, wdata: 32'h0};
    @(negedge core_clk_i);
    req.valid = 1'b0;
    check("rvalid", 32'(rvalid), 32'h1);
    data = rdata;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [31:0] data, input logic core);
    @(negedge core_clk_i);
    req = '{valid: 1'b1, write: 1'b1, from_core: core, index: idx, wdata: data};
    @(negedge core_clk_i);
    req.valid = 1'b0;
  endtask

  // Expected status word; own id zero forces master id one
  function automatic logic [31:0] exp_status(sys_obs_type o, logic dwp, logic vip);
    logic [31:0] s;
    s        = 32'h0;
    s[0]     = o.host_owns_bus;
    s[1]     = o.arbitration_synced;
    s[10:8]  = (o.own_id_code == 3'h0) ? 3'h1 : o.current_master_id;
    s[13:11] = o.own_id_code;
    s[15]    = dwp;
    s[16]    = vip;
    s[18:17] = (o.host_pack_stage == 2'h3) ? 2'h0 : o.host_pack_stage;
    return s;
  endfunction

  // Trigger and walk push, five nops, branch
  task automatic vector_walk(input logic [31:0] v);
    wr(VECTOR_IDX, v, 1'b0);
    check("push", 32'(push), 32'h1);
    for (int k = 1; k <= 5; k++)
    begin
      @(negedge core_clk_i);
      check("nop", 32'(nop), 32'h1);
      check("branch", 32'(branch), 32'(k == 5));
    end
    check("target", 32'(target), 32'(v[23:0]));
    @(negedge core_clk_i);
    check("nop end", 32'(nop), 32'h0);
  endtask

  task automatic do_rti();
    @(negedge core_clk_i);
    return_from_interrupt = 1'b1;
    #1 check("pop", 32'(pop), 32'h1);
    @(negedge core_clk_i);
    return_from_interrupt = 1'b0;
  endtask

  // Hang guard
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'ha79b592c));
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    rd(VECTOR_IDX, d);
    check("vector reset", d, VECTOR_RESET);
    // Messages, zero included as the write-back cleared value
    for (int i = 0; i < 8; i++)
    begin
      msg[i] = (i == 3) ? 32'h0 : $urandom();
      wr(MSG_BASE_IDX + 4'(i), msg[i], 1'b0);
    end
    for (int i = 0; i < 8; i++)
    begin
      rd(MSG_BASE_IDX + 4'(i), d);
      check("message", d, msg[i]);
    end
    for (int i = 10; i < 16; i++)
    begin
      rd(4'(i), d);
      check("unmapped", d, 32'h0);
    end
    // Status fields under random observed state, writes ignored
    for (int i = 0; i < 8; i++)
    begin
      obs = sys_obs_type'(10'($urandom()));
      if (i == 0)
        obs.own_id_code = 3'h0;
      wr(STATUS_IDX, $urandom(), 1'b0);
      repeat (2) @(negedge core_clk_i);
      rd(STATUS_IDX, d);
      check("status", d, exp_status(obs, 1'b0, 1'b0));
    end
    // Direct write, then poll pending clear before any vector
    dly = 4'hc;
    go = 1'b1;
    @(negedge core_clk_i);
    go = 1'b0;
    // Model, pending flag and status word each add a register stage
    @(negedge core_clk_i);
    rd(STATUS_IDX, d);
    check("dwp set", 32'(d[15]), 32'h1);
    n = 0;
    while (d[15] !== 1'b0 && n < 10)
    begin
      rd(STATUS_IDX, d);
      n++;
    end
    check("dwp clear", 32'(d[15]), 32'h0);
    // Vector interrupt and its service
    a = $urandom() | 32'h1;
    vector_walk(a);
    rd(STATUS_IDX, d);
    check("vip set", 32'(d[16]), 32'h1);
    b = $urandom() | 32'h1;
    wr(VECTOR_IDX, b, 1'b0);
    n = 0;
    repeat (8)
    begin
      @(negedge core_clk_i);
      n += int'(push);
    end
    check("no retrigger", 32'(n), 32'h0);
    rd(VECTOR_IDX, d);
    check("vector kept", d, a);
    wr(VECTOR_IDX, 32'h0, 1'b1);
    rd(VECTOR_IDX, d);
    check("token", d, 32'h0);
    do_rti();
    repeat (2) @(negedge core_clk_i);
    rd(STATUS_IDX, d);
    check("vip clear", 32'(d[16]), 32'h0);
    // Rewrite while pending replaces the target
    a = $urandom();
    b = $urandom();
    wr(VECTOR_IDX, a, 1'b0);
    wr(VECTOR_IDX, b, 1'b0);
    n = 0;
    while (branch !== 1'b1 && n < 12)
    begin
      @(negedge core_clk_i);
      n++;
    end
    check("branch seen", 32'(branch), 32'h1);
    check("replaced", 32'(target), 32'(b[23:0]));
    do_rti();
    // Own core writes never trigger
    repeat (3) @(negedge core_clk_i);
    wr(VECTOR_IDX, $urandom(), 1'b1);
    n = 0;
    repeat (8)
    begin
      @(negedge core_clk_i);
      n += int'(push);
    end
    check("core write", 32'(n), 32'h0);
    rd(VECTOR_IDX, d);
    check("core vector", d, b);
    report_and_stop();
  end
endmodule // interprocessor_mailbox_vector_irq_test
